/* logic/paired_channel_pwm.sv */
// paired channel pwm: master interval timer plus slave one-count channel
// assumes a register port with read data one cycle later and one 20 MHz clock
// Functional notes
// RULE1: master sets period, slave sets duty
// RULE2: period is master value plus one
// RULE3: duty is slave over period plus one
// RULE4: zero duty keeps output inactive
// RULE5: large duty saturates to full active
// RULE6: start raises tick, loads, counts down
// RULE7: zero reloads and repeats until stopped
// RULE8: master tick retriggers slave load
// RULE9: slave zero raises done and stops
// RULE10: active one count after tick
// RULE11: software rewrites values after master tick
// RULE12: master mode set by software
// RULE13: slave mode set by software
// RULE14: both channels share clock source
// RULE15: polarity bit selects active level
// RULE16: software sets output mode bits
// RULE17: enable bit selects counting or level
// RULE18: power bit gates clock and writes
// RULE19: stopped channel holds output
// RULE20: slave numbered above master
// RULE21: triggers self-clear after start
// RULE22: stop clears status, holds counts
// RULE23: master retrigger beats slave zero
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "pwm_params.svh"
module paired_channel_pwm (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire pwm_pkg::reg_req_t req,
  output logic [15:0] rdata,
  // events
  output logic master_tick_irq,
  output logic slave_done_irq,
  // pin
  output logic pwm_out
);
  import pwm_pkg::*;

  logic timer_unit_power_enable; // unit clock and write gate
  logic [15:0] prescaler_select_reg; // low byte clock a, high byte clock b
  logic [15:0] master_channel_mode; // master mode word
  logic [15:0] slave_channel_mode; // slave mode word
  logic [15:0] master_period_value; // period reload
  logic [15:0] slave_duty_value; // duty reload
  logic [15:0] master_counter; // master down counter
  logic [15:0] slave_counter; // slave down counter
  logic master_run_status; // master running
  logic slave_run_status; // slave enabled
  out_ctrl_t out_ctrl; // output control bits
  logic [1:0] pair_select; // slave channel number, 1 to 3 above master 0
  slave_state_t slave_state; // slave counting or waiting
  logic active; // slave output active
  logic tick; // count clock enable
  logic wr_ok; // write accepted
  logic start_m, start_s, stop_m, stop_s; // trigger pulses
  logic master_zero; // master reached zero on a tick
  logic master_event; // master interrupt this cycle
  logic [7:0] divisor; // selected prescale

  // RULE18: writes only while powered, except to the power register
  assign wr_ok = req.wr && (timer_unit_power_enable || req.addr == `REG_POWER);
  // RULE21: trigger bits exist only as pulses
  assign start_m = wr_ok && req.addr == `REG_START && req.wdata[`TRIG_MASTER];
  assign start_s = wr_ok && req.addr == `REG_START && req.wdata[`TRIG_SLAVE];
  assign stop_m = wr_ok && req.addr == `REG_STOP && req.wdata[`TRIG_MASTER];
  assign stop_s = wr_ok && req.addr == `REG_STOP && req.wdata[`TRIG_SLAVE];

  // RULE14: shared clock source from master mode
  assign divisor = (master_channel_mode[`MODE_CKS_HI:`MODE_CKS_LO] == `CKS_B) ?
                   prescaler_select_reg[15:8] : prescaler_select_reg[7:0];

  // count clock enable
  count_tick u_tick (
    .clk(clk),
    .rst(rst),
    .run(timer_unit_power_enable),
    .divisor(divisor),
    .tick(tick)
  );

  // power register; clearing it resets every channel register
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_unit_power_enable <= 1'b0;
    end else if (req.wr && req.addr == `REG_POWER) begin
      timer_unit_power_enable <= req.wdata[0];
    end
  end

  // configuration registers, loaded with reset values while powered down
  always_ff @(posedge clk) begin
    if (rst || !timer_unit_power_enable) begin
      prescaler_select_reg <= `RST_WORD16;
      master_channel_mode <= `RST_WORD16;
      slave_channel_mode <= `RST_WORD16;
      master_period_value <= `RST_WORD16;
      slave_duty_value <= `RST_WORD16;
      out_ctrl <= '0;
      pair_select <= `RST_PAIR;
    end else if (wr_ok) begin
      unique case (req.addr)
        `REG_PRESCALE: prescaler_select_reg <= req.wdata;
        `REG_MASTER_MODE: master_channel_mode <= req.wdata;
        `REG_SLAVE_MODE: slave_channel_mode <= req.wdata;
        // RULE11: new values take effect at next tick
        `REG_MASTER_PERIOD: master_period_value <= req.wdata;
        `REG_SLAVE_DUTY: slave_duty_value <= req.wdata;
        `REG_OUT_CTRL: out_ctrl <= req.wdata[6:0];
        // RULE20: slave 1 to 3 above master 0
        `REG_PAIR_SELECT: pair_select <= (req.wdata[1:0] == 2'h0) ? 2'h1 : req.wdata[1:0];
        default: ;
      endcase
    end
  end

  // run status: start sets, stop clears
  always_ff @(posedge clk) begin
    if (rst || !timer_unit_power_enable) begin
      master_run_status <= 1'b0;
      slave_run_status <= 1'b0;
    end else begin
      // RULE22: stop clears status
      if (stop_m) begin
        master_run_status <= 1'b0;
      end else if (start_m) begin
        master_run_status <= 1'b1;
      end
      if (stop_s) begin
        slave_run_status <= 1'b0;
      end else if (start_s) begin
        slave_run_status <= 1'b1;
      end
    end
  end

  assign master_zero = master_run_status && tick && master_counter == `ZERO16;
  // RULE6: tick at start as well
  assign master_event = (start_m && !stop_m) || (master_zero && !stop_m);

  // master counter
  always_ff @(posedge clk) begin
    if (rst || !timer_unit_power_enable) begin
      master_counter <= `ZERO16;
    // RULE7: reload at zero and on start
    end else if (master_event) begin
      master_counter <= master_period_value;
    // RULE2: counts period plus one ticks
    end else if (master_run_status && tick) begin
      master_counter <= master_counter - `ONE16;
    end
  end

  // master interrupt pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      master_tick_irq <= 1'b0;
    end else begin
      master_tick_irq <= master_event;
    end
  end

  // slave channel: one count mode, retriggered by master
  always_ff @(posedge clk) begin
    if (rst || !timer_unit_power_enable) begin
      slave_counter <= `ZERO16;
      slave_state <= slave_idle;
      active <= 1'b0;
      slave_done_irq <= 1'b0;
    end else begin
      slave_done_irq <= 1'b0;
      // RULE23: retrigger first
      if (master_event && (slave_run_status || start_s)) begin
        // RULE8: load duty on master tick
        slave_counter <= slave_duty_value;
        slave_state <= slave_count;
        // RULE10: a duty that ends on the reload tick still drops for one count,
        // otherwise a duty of exactly the period value would read as full active
        if (slave_state == slave_count && tick && slave_counter == `ZERO16) begin
          active <= 1'b0;
        end
      end else if (slave_run_status && tick) begin
        unique case (slave_state)
          slave_count: begin
            // RULE10: active on first count after tick
            if (slave_counter == `ZERO16) begin
              // RULE9: done and wait
              active <= 1'b0;
              slave_done_irq <= 1'b1;
              slave_state <= slave_idle;
            end else begin
              // RULE3: active for duty ticks
              active <= 1'b1;
              slave_counter <= slave_counter - `ONE16;
            end
          end
          slave_idle: ;
        endcase
      end
    end
  end
  // RULE1: pair drives one waveform
  // RULE4: zero duty never sets active
  // RULE5: duty beyond period is reloaded before zero

  // output stage
  pin_out u_pin (
    .clk(clk),
    .rst(rst),
    .ctrl(out_ctrl),
    .running(slave_run_status),
    .active(active),
    .pin(pwm_out)
  );

  // read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `ZERO16;
    end else if (req.rd) begin
      unique case (req.addr)
        `REG_POWER: rdata <= {15'h0000, timer_unit_power_enable};
        `REG_PRESCALE: rdata <= prescaler_select_reg;
        `REG_MASTER_MODE: rdata <= master_channel_mode;
        `REG_SLAVE_MODE: rdata <= slave_channel_mode;
        `REG_MASTER_PERIOD: rdata <= master_period_value;
        `REG_SLAVE_DUTY: rdata <= slave_duty_value;
        `REG_RUN_STATUS: rdata <= {14'h0000, slave_run_status, master_run_status};
        `REG_OUT_CTRL: rdata <= {9'h000, out_ctrl};
        `REG_MASTER_COUNT: rdata <= master_counter;
        `REG_SLAVE_COUNT: rdata <= slave_counter;
        `REG_PAIR_SELECT: rdata <= {14'h0000, pair_select};
        default: rdata <= `ZERO16;
      endcase
    end else begin
      rdata <= `ZERO16;
    end
  end
endmodule // paired_channel_pwm

/* logic/pwm_params.svh */
// constants for the paired channel pwm block: register indices, field positions, reset values
// assumes inclusion by bare name from the package and the modules
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH
// register indices (word address = index)
`define REG_POWER 4'h0
`define REG_PRESCALE 4'h1
`define REG_MASTER_MODE 4'h2
`define REG_SLAVE_MODE 4'h3
`define REG_MASTER_PERIOD 4'h4
`define REG_SLAVE_DUTY 4'h5
`define REG_START 4'h6
`define REG_STOP 4'h7
`define REG_RUN_STATUS 4'h8
`define REG_OUT_CTRL 4'h9
`define REG_MASTER_COUNT 4'ha
`define REG_SLAVE_COUNT 4'hb
`define REG_PAIR_SELECT 4'hc
// out_ctrl fields
`define OC_LEVEL 0
`define OC_ENABLE 1
`define OC_POLARITY 2
`define OC_SLAVE_MODE 3
`define OC_MASTER_MODE 4
`define OC_MASTER_POL 5
`define OC_MASTER_EN 6
// trigger bits in start and stop registers
`define TRIG_MASTER 0
`define TRIG_SLAVE 1
// mode register field position: clock source bits
`define MODE_CKS_HI 15
`define MODE_CKS_LO 14
`define CKS_B 2'h2
// reset values and count constants
`define RST_WORD16 16'h0000
`define RST_PAIR 2'h1
`define ZERO16 16'h0000
`define ONE16 16'h0001
`define ZERO8 8'h00
`endif

/* logic/pwm_pkg.sv */
// types shared by the paired channel pwm block
// assumes the params header is on the include path
`include "pwm_params.svh"
package pwm_pkg;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // output control bits
  typedef struct packed {
    logic master_en;
    logic master_pol;
    logic master_mode;
    logic slave_mode;
    logic polarity;
    logic enable;
    logic level;
  } out_ctrl_t;
  // slave channel state
  typedef enum logic [0:0] {slave_idle, slave_count} slave_state_t;
endpackage

/* logic/count_tick.sv */
// count clock enable divider for the timer unit
// assumes one 20 MHz clock; divisor selected per clock source
`timescale 1ns/10ps
`include "pwm_params.svh"
module count_tick (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [7:0] divisor,
  // enable pulse
  output logic tick
);
  import pwm_pkg::*;
  logic [7:0] count; // cycles since last tick
  // divider: a tick every divisor+1 cycles while the unit runs
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count <= `ZERO8;
    end else if (count >= divisor) begin
      count <= `ZERO8;
    end else begin
      count <= count + 8'h01;
    end
  end
  assign tick = run && (count >= divisor);
endmodule // count_tick

/* logic/pin_out.sv */
// output pin stage: drives the level from counting or from the level bit
// assumes the caller provides the active state of the slave counter
`timescale 1ns/10ps
`include "pwm_params.svh"
module pin_out (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire pwm_pkg::out_ctrl_t ctrl,
  input wire logic running,
  input wire logic active,
  // pin
  output logic pin
);
  import pwm_pkg::*;
  // level held while stopped with the enable bit set, so the pin does not jump on a stop
  always_ff @(posedge clk) begin
    if (rst) begin
      pin <= 1'b0;
    // RULE17: level bit direct
    end else if (!ctrl.enable) begin
      pin <= ctrl.level;
    // RULE19: hold while stopped
    end else if (running) begin
      // RULE15: polarity select
      pin <= active ^ ctrl.polarity;
    end
  end
endmodule // pin_out

/* test/pwm_chk.sv */
// port checker for the paired channel pwm block, bound to its top module
// assumes one clock and the register indices of the params header
`timescale 1ns/10ps
`include "pwm_params.svh"
module pwm_chk import pwm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire pwm_pkg::reg_req_t req,
  input wire logic [15:0] rdata,
  // events and pin
  input wire logic master_tick_irq,
  input wire logic slave_done_irq,
  input wire logic pwm_out
);
  logic pwr; // power bit shadow
  logic [6:0] oc; // output control shadow, cleared while powered down
  logic rd_off; // duty read taken while powered down
  logic stop_wr; // both stop triggers in one write
  assign stop_wr = req.wr && req.addr == `REG_STOP && req.wdata[1:0] == 2'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shadows follow accepted writes, so the checks need no view inside
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr <= 1'b0;
      oc <= 7'h00;
      rd_off <= 1'b0;
    end else begin
      if (req.wr && req.addr == `REG_POWER)
        pwr <= req.wdata[0];
      if (!pwr)
        oc <= 7'h00;
      else if (req.wr && req.addr == `REG_OUT_CTRL)
        oc <= req.wdata[6:0];
      rd_off <= req.rd && !pwr && req.addr == `REG_SLAVE_DUTY;
    end
  end
  a_tick_beats_done: assert property (master_tick_irq |-> !slave_done_irq)
    else $error("done pulse beside a master tick");
  a_done_single: assert property (slave_done_irq |=> !slave_done_irq)
    else $error("done pulse longer than one cycle");
  a_start_ticks: assert property (
    pwr && req.wr && req.addr == `REG_START && req.wdata[0] |-> ##[1:2] master_tick_irq)
    else $error("no master tick after start");
  a_stop_quiets: assert property (
    stop_wr |-> ##2 (!master_tick_irq && !slave_done_irq)[*8])
    else $error("events after stop");
  a_stop_holds_pin: assert property (stop_wr |-> ##2 $stable(pwm_out)[*8])
    else $error("pin moved after stop");
  a_power_quiet: assert property (
    (!pwr)[*3] |-> !master_tick_irq && !slave_done_irq && !pwm_out)
    else $error("activity while powered down");
  a_power_reads: assert property (rd_off |-> rdata == 16'h0000)
    else $error("write accepted while powered down");
  a_enable_level: assert property (
    (!oc[1] && $stable(oc))[*3] |-> pwm_out == oc[0])
    else $error("pin differs from level bit");
endmodule // pwm_chk
bind paired_channel_pwm pwm_chk pwm_chk_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
  .master_tick_irq(master_tick_irq), .slave_done_irq(slave_done_irq), .pwm_out(pwm_out));

/* test/testbench.sv */
// self-checking bench for the paired channel pwm block
// assumes the register map of the params header and read data one cycle after rd
`timescale 1ns/10ps
`include "pwm_params.svh"
module testbench;
  import pwm_pkg::*;
  logic clk; // 20 MHz bench clock
  logic rst; // synchronous reset
  reg_req_t req; // register request
  logic [15:0] rdata; // read data
  logic master_tick_irq; // period event
  logic slave_done_irq; // duty end event
  logic pwm_out; // output pin
  int error_cnt; // mismatches
  int num_checks; // comparisons made
  logic [15:0] rd_q[$]; // expected read data, oldest first
  logic rd_d = 1'b0; // a read was taken at the last edge
  logic pol; // active-low output selected
  int p, dv, d, cc, per, act;
  paired_channel_pwm paired_channel_pwm_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .master_tick_irq(master_tick_irq), .slave_done_irq(slave_done_irq), .pwm_out(pwm_out));
  always #25 clk = ~clk;
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // compare a design value
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  // compare a measured cycle count
  task automatic cmp_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  // one write cycle, then a gap so the strobe never toggles twice in a step
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req <= '{a, v, 1'b0, 1'b0};
    @(posedge clk);
  endtask
  // one read cycle; the expected word is noted for the monitor
  task automatic rd(input logic [3:0] a, input logic [15:0] v);
    rd_q.push_back(v);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '{a, 16'h0000, 1'b0, 1'b0};
    @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= req.rd;
    if (rd_d && rd_q.size() > 0)
      cmp16(rdata, rd_q.pop_front());
  end
  // cycles from one master tick to the next, and active cycles among them
  task automatic measure(output int np, output int na);
    int k;
    k = 0;
    np = 0;
    na = 0;
    while (master_tick_irq !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    do begin
      @(posedge clk);
      np++;
      if (pwm_out === ~pol)
        na++;
    end while (master_tick_irq !== 1'b1 && np < 2000);
    if (k >= 2000 || np >= 2000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: no master tick", $time);
      stop_test();
    end
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    pol = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(32'hfdeb));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // powered down: writes dropped
    wr(`REG_SLAVE_DUTY, 16'h0005);
    rd(`REG_SLAVE_DUTY, 16'h0000);
    wr(`REG_POWER, 16'h0001);
    rd(`REG_RUN_STATUS, 16'h0000);
    rd(4'hf, 16'h0000);
    rd(`REG_PAIR_SELECT, 16'h0001);
    // zero, partial, exact and over-range duty; both polarities and clock sources
    for (int i = 0; i < 4; i++) begin
      p = 3 + $urandom % 6;
      dv = $urandom % 3;
      cc = dv + 1 + i[1];
      pol = i[0];
      d = (i == 0) ? 0 : (i == 1) ? 1 + $urandom % p : (i == 2) ? p + 1 : p + 3;
      wr(`REG_PRESCALE, {8'(dv + 1), 8'(dv)});
      wr(`REG_MASTER_MODE, {i[1], 15'h0801});
      wr(`REG_SLAVE_MODE, {i[1], 15'h0409});
      rd(`REG_SLAVE_MODE, {i[1], 15'h0409});
      // start on other values, so the rewrite below must really reload
      wr(`REG_MASTER_PERIOD, 16'(p + 2));
      wr(`REG_SLAVE_DUTY, 16'(p));
      wr(`REG_OUT_CTRL, {12'h000, 1'b1, pol, 2'h2});
      wr(`REG_START, 16'h0003);
      rd(`REG_RUN_STATUS, 16'h0003);
      measure(per, act);
      // both values rewritten right after a master tick land before the next one
      wr(`REG_MASTER_PERIOD, 16'(p));
      wr(`REG_SLAVE_DUTY, 16'(d));
      measure(per, act);
      measure(per, act);
      cmp_cnt(per, (p + 1) * cc);
      cmp_cnt(act, ((d < p + 1) ? d : p + 1) * cc);
      wr(`REG_STOP, 16'h0003);
      rd(`REG_RUN_STATUS, 16'h0000);
      repeat (10) @(posedge clk);
    end
    // counting released from the pin: level bit shows directly
    wr(`REG_OUT_CTRL, 16'h0009);
    repeat (3) @(posedge clk);
    cmp16({15'h0000, pwm_out}, 16'h0001);
    wr(`REG_OUT_CTRL, 16'h0008);
    repeat (3) @(posedge clk);
    cmp16({15'h0000, pwm_out}, 16'h0000);
    @(posedge clk);
    stop_test();
  end
endmodule // testbench
